// ---- pkg/pomr_cfg.svh ----
// Purpose: offsets, field positions and reset values of the option bank
// Assumes: 8-bit register port, 4-bit address
// Notes:   offsets and reset values chosen for this block
`ifndef POMR_CFG_SVH
`define POMR_CFG_SVH

// ==========================================================================
// offsets
`define POMR_OFS_OD      4'h0
`define POMR_OFS_PH      4'h1
`define POMR_OFS_WDT     4'h2
`define POMR_OFS_MASK    4'h3
`define POMR_OFS_FLAG    4'h4
`define POMR_OFS_P5      4'h5
`define POMR_OFS_GIE     4'h6

// ==========================================================================
// field positions
`define POMR_WDT_EN_BIT  7
`define POMR_INT_SEL_BIT 6
`define POMR_PH_UNUSED   4
`define POMR_GIE_BIT     0

// ==========================================================================
// reset values and used-bit masks
`define POMR_RST_OD      8'hFF
`define POMR_RST_PH      8'hEF
`define POMR_RST_WDT     8'h00
`define POMR_RST_MASK    8'h00
`define POMR_MASK_USED   8'h7F
`define POMR_PH_USED     8'hEF

`endif

// ---- pkg/pomr_pkg.sv ----
// Purpose: types of the option and mask register bank
// Assumes: nothing beyond the cfg header
// Notes:   pad group carries per-pin controls
package pomr_pkg;

	typedef struct packed {
		logic [3:0] p6_od_n;   // port6 pins 7..4
		logic [3:0] p5_od_n;   // port5 pins 7,4,2,1
		logic [3:0] p6_ph_n;   // port6 pins 3..0
		logic [2:0] p5_ph_n;   // port5 pins 6,5,3
	} pomr_pad_s;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} pomr_req_s;

endpackage

// ---- src/pomr_flag_bit.sv ----
// Purpose: one sticky interrupt flag, set by hardware, cleared by software
// Assumes: event is one clk_sys cycle or longer, same domain
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/1ps
module pomr_flag_bit (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// set and clear
	input  wire logic set_evt,
	input  wire logic clr,
	// state
	output logic      flag
);

	// ======================================================================
	// flag storage
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			flag <= 1'b0;
		else if (set_evt)
			flag <= 1'b1;
		else if (clr)
			flag <= 1'b0;
	end

endmodule

// ---- src/pomr_regs.sv ----
// Purpose: open-drain, pull-high, watchdog/int-pin and interrupt mask bank
// Assumes: one clock, synchronous active-low reset, 8-bit register port
// Notes:   flag sources and pins come from outside; pins are synchronised
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "pomr_cfg.svh"

module pomr_regs
	import pomr_pkg::*;
#(
	parameter int NFLAG = 7
)(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// register port
	input  wire pomr_req_s         req,
	output logic [7:0]             rdata,
	// core instruction strobes
	input  wire logic              gie_on,
	input  wire logic              gie_off,
	// flag sources other than the pin, one-cycle events
	input  wire logic [NFLAG-1:0]  src_evt,
	// port5 pins and direction
	input  wire logic [7:0]        p5_pin,
	input  wire logic              p5_dir0,
	// controls out
	output pomr_pad_s              pad,
	output logic                   wdt_en,
	output logic                   int_pin_sel,
	output logic                   irq_req
);

	// ======================================================================
	// storage
	logic [7:0]       od_sel;
	logic [7:0]       ph_sel;
	logic [6:0]       mask;
	logic             gie;
	logic [NFLAG-1:0] flags;
	logic [NFLAG-1:0] next_set;
	logic [NFLAG-1:0] clr;
	logic [7:0]       p5_m;
	logic [7:0]       p5_s;
	logic             int_prev;
	logic             wr_en;

	assign wr_en = req.wr;

	// one clock domain, so every check shares this clock and reset
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ======================================================================
	// pin synchroniser, first stage read only by second
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			p5_m <= 8'hFF;
			p5_s <= 8'hFF;
		end
		else
		begin
			p5_m <= p5_pin;
			p5_s <= p5_m;
		end
	end

	// ======================================================================
	// control registers
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			od_sel <= `POMR_RST_OD;
		else if (wr_en && req.addr == `POMR_OFS_OD)
			od_sel <= req.wdata;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			ph_sel <= `POMR_RST_PH;
		else if (wr_en && req.addr == `POMR_OFS_PH)
			ph_sel <= req.wdata & `POMR_PH_USED;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			wdt_en      <= 1'b0;
			int_pin_sel <= 1'b0;
		end
		else if (wr_en && req.addr == `POMR_OFS_WDT)
		begin
			wdt_en      <= req.wdata[`POMR_WDT_EN_BIT];
			int_pin_sel <= req.wdata[`POMR_INT_SEL_BIT];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			mask <= 7'h00;
		else if (wr_en && req.addr == `POMR_OFS_MASK)
			mask <= req.wdata[6:0];
	end

	// global enable, an off strobe beats an on strobe
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			gie <= 1'b0;
		else if (gie_off)
			gie <= 1'b0;
		else if (gie_on)
			gie <= 1'b1;
		else if (wr_en && req.addr == `POMR_OFS_GIE)
			gie <= req.wdata[`POMR_GIE_BIT];
	end

	// ======================================================================
	// pad controls, straight from flops
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			pad <= '1;
		else
		begin
			pad.p6_od_n <= od_sel[3:0];
			pad.p5_od_n <= od_sel[7:4];
			pad.p6_ph_n <= ph_sel[3:0];
			pad.p5_ph_n <= ph_sel[7:5];
		end
	end

	// ======================================================================
	// flags; falling edge on the pin only counts when selected as input
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			int_prev <= 1'b1;
		else
			int_prev <= p5_s[0];
	end

	always_comb
	begin
		next_set    = src_evt;
		next_set[2] = src_evt[2] | (int_pin_sel & p5_dir0 &
			int_prev & ~p5_s[0]);
		if (!int_pin_sel)
			next_set[2] = 1'b0;
		clr = '0;
		if (wr_en && req.addr == `POMR_OFS_FLAG)
			clr = ~req.wdata[NFLAG-1:0];
	end

	genvar gi;
	generate
		for (gi = 0; gi < NFLAG; gi++)
		begin : g_flag
			pomr_flag_bit u_flag (
				.clk_sys (clk_sys),
				.rst_n   (rst_n),
				.set_evt (next_set[gi]),
				.clr     (clr[gi]),
				.flag    (flags[gi])
			);
		end
	endgenerate

	// request registered; raised only with global enable
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			irq_req <= 1'b0;
		else
			irq_req <= gie & |(flags & mask);
	end

	// ======================================================================
	// read port, data one cycle after the strobe
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (req.rd)
		begin
			case (req.addr)
				`POMR_OFS_OD:   rdata <= od_sel;
				`POMR_OFS_PH:   rdata <= ph_sel;
				`POMR_OFS_WDT:  rdata <= {wdt_en, int_pin_sel, 6'h00};
				`POMR_OFS_MASK: rdata <= {1'b0, mask};
				`POMR_OFS_FLAG: rdata <= {1'b0, flags & mask};
				`POMR_OFS_P5:   rdata <= p5_s;
				`POMR_OFS_GIE:  rdata <= {7'h00, gie};
				default:        rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end

	// ======================================================================
	// checks on the read port
	AST_FLAG_READ: assert property (
		req.rd && req.addr == `POMR_OFS_FLAG
		|=> rdata == {1'b0, $past(flags) & $past(mask)})
		else $error("flag read not masked");
	AST_UNUSED_ZERO: assert property (
		req.rd && req.addr == `POMR_OFS_WDT
		|=> rdata[5:0] == 6'h00)
		else $error("unused watchdog bits read nonzero");
	AST_MASK_READ: assert property (
		req.rd && req.addr == `POMR_OFS_MASK
		|=> rdata == {1'b0, $past(mask)})
		else $error("mask read wrong or top bit set");
	AST_UNMAPPED: assert property (
		req.rd && req.addr > `POMR_OFS_GIE
		|=> rdata == 8'h00)
		else $error("unmapped index read nonzero");
	AST_P5_READ: assert property (
		req.rd && req.addr == `POMR_OFS_P5
		|=> rdata == $past(p5_s))
		else $error("port5 read does not show the pins");

	// ======================================================================
	// checks on the flags and the request
	AST_NO_SW_SET: assert property (
		(flags & ~$past(flags) & ~$past(next_set)) == '0)
		else $error("flag set without event");
	AST_FLAG_CLEAR: assert property (
		|clr |=> (flags & $past(clr) & ~$past(next_set)) == '0)
		else $error("flag written zero not cleared");
	AST_EXT_BLOCK: assert property (
		!int_pin_sel && !flags[2] |=> !flags[2])
		else $error("pin raised flag while deselected");
	AST_IRQ_GATE: assert property (
		irq_req |-> $past(gie) && |($past(flags) & $past(mask)))
		else $error("request without enables");
	AST_IRQ_TAKE: assert property (
		gie && |(flags & mask) |=> irq_req)
		else $error("enabled flag raised no request");
	AST_GIE_OFF: assert property (
		gie_off |=> !gie)
		else $error("global enable survived the off strobe");

	// ======================================================================
	// checks on the control registers and pads
	AST_OD_WRITE: assert property (
		req.wr && req.addr == `POMR_OFS_OD
		|=> od_sel == $past(req.wdata))
		else $error("open-drain write lost");
	AST_PH_WRITE: assert property (
		req.wr && req.addr == `POMR_OFS_PH
		|=> ph_sel == ($past(req.wdata) & `POMR_PH_USED))
		else $error("pull-high write lost");
	AST_PH_UNUSED: assert property (
		!ph_sel[`POMR_PH_UNUSED])
		else $error("unused pull-high bit holds a one");
	AST_WDT_WRITE: assert property (
		req.wr && req.addr == `POMR_OFS_WDT
		|=> wdt_en == $past(req.wdata[7])
		&& int_pin_sel == $past(req.wdata[6]))
		else $error("watchdog control write lost");
	AST_WDT_HOLD: assert property (
		!(req.wr && req.addr == `POMR_OFS_WDT)
		|=> $stable(wdt_en) && $stable(int_pin_sel))
		else $error("watchdog control changed without a write");
	AST_MASK_WRITE: assert property (
		req.wr && req.addr == `POMR_OFS_MASK
		|=> mask == $past(req.wdata[6:0]))
		else $error("mask write lost");
	AST_PAD_MAP: assert property (
		pad.p5_od_n == $past(od_sel[7:4])
		&& pad.p6_od_n == $past(od_sel[3:0]))
		else $error("open-drain mapping wrong");
	AST_PH_MAP: assert property (
		pad.p5_ph_n == $past(ph_sel[7:5])
		&& pad.p6_ph_n == $past(ph_sel[3:0]))
		else $error("pull-high mapping wrong");

	// ======================================================================
	// scenarios worth seeing
	COV_IRQ: cover property ($rose(irq_req));
	COV_EXT: cover property (next_set[2] && int_pin_sel);
	COV_CLR: cover property (|clr && |flags);
	COV_GIE_OFF: cover property (gie_off && gie);
	COV_PIN_READ: cover property (req.rd && req.addr == `POMR_OFS_P5);

endmodule

// ---- dv/tb_pin_option_wdt_irq_mask_regs.sv ----
// Purpose: self-checking bench for the option and mask register bank
// Assumes: 200 MHz clk_sys, sync active-low reset, read data one cycle late
// Notes:   random register traffic from a fixed seed, plus flag and pin cases
`timescale 1ns/1ps
`include "pomr_cfg.svh"
module tb_pin_option_wdt_irq_mask_regs
	import pomr_pkg::*;
;
	logic             clk_sys = 1'b0;
	logic             rst_n   = 1'b0;
	pomr_req_s        req     = '0;
	logic [7:0]       rdata;
	logic             gie_on  = 1'b0;
	logic             gie_off = 1'b0;
	logic [6:0]       src_evt = '0;
	logic [7:0]       p5_pin  = 8'hFF;
	logic             p5_dir0 = 1'b0;
	pomr_pad_s        pad;
	logic             wdt_en;
	logic             int_pin_sel;
	logic             irq_req;
	int               fails = 0;
	int               samples_checked = 0;
	int               seed = 93;
	logic [7:0]       d;
	logic [7:0]       v;
	logic [3:0]       a;
	logic [7:0]       shadow [4];
	logic [7:0]       rst_tab [4] = '{`POMR_RST_OD, `POMR_RST_PH,
		`POMR_RST_WDT, `POMR_RST_MASK};

	always #2.5 clk_sys = ~clk_sys;

	pomr_regs DUT (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.req         (req),
		.rdata       (rdata),
		.gie_on      (gie_on),
		.gie_off     (gie_off),
		.src_evt     (src_evt),
		.p5_pin      (p5_pin),
		.p5_dir0     (p5_dir0),
		.pad         (pad),
		.wdt_en      (wdt_en),
		.int_pin_sel (int_pin_sel),
		.irq_req     (irq_req)
	);

	// ======================================================================
	// helpers
	`define TB_CHK(g, e) check_val(16'(g), 16'(e))
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// unused bits read zero, so the expected readback is masked
	function automatic logic [7:0] used_bits(input logic [3:0] ad);
		case (ad)
			`POMR_OFS_PH:   used_bits = `POMR_PH_USED;
			`POMR_OFS_WDT:  used_bits = 8'hC0;
			`POMR_OFS_MASK: used_bits = `POMR_MASK_USED;
			default:        used_bits = 8'hFF;
		endcase
	endfunction
	function automatic logic [14:0] exp_pad(input logic [7:0] od, ph);
		exp_pad = {od[3:0], od[7:4], ph[3:0], ph[7:5]};
	endfunction
	task automatic wr(input logic [3:0] ad, input logic [7:0] wd);
		@(posedge clk_sys);
		req <= '{1'b1, 1'b0, ad, wd};
		@(posedge clk_sys);
		req <= '0;
	endtask
	task automatic rd(input logic [3:0] ad, output logic [7:0] rd_val);
		@(posedge clk_sys);
		req <= '{1'b0, 1'b1, ad, 8'h00};
		@(posedge clk_sys);
		req <= '0;
		#1 rd_val = rdata;
	endtask
	task automatic pulse(input int sel);
		@(posedge clk_sys);
		if (sel < 0)
			gie_off <= 1'b1;
		else if (sel > 7)
			gie_on <= 1'b1;
		else
			src_evt <= 7'(8'h01 << sel);
		@(posedge clk_sys);
		{gie_on, gie_off, src_evt} <= '0;
		repeat (3) @(posedge clk_sys);
	endtask

	// ======================================================================
	// hang guard
	initial
	begin
		#200000;
		fails++;
		report_and_stop();
	end

	// ======================================================================
	// main sequence
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1 `TB_CHK(pad, 15'h7FFF);
		foreach (rst_tab[i])
		begin
			rd(4'(i), d);
			`TB_CHK(d, rst_tab[i]);
			shadow[i] = rst_tab[i];
		end
		// random traffic; the pad mapping is rechecked after every write
		repeat (40)
		begin
			a = 4'($unsigned($random(seed)) % 4);
			v = 8'($random(seed));
			wr(a, v);
			shadow[a] = v & used_bits(a);
			rd(a, d);
			`TB_CHK(d, shadow[a]);
			`TB_CHK(pad, exp_pad(shadow[0], shadow[1]));
			`TB_CHK({wdt_en, int_pin_sel}, shadow[2][7:6]);
		end
		for (int i = 7; i < 16; i++)
		begin
			wr(4'(i), 8'hFF);
			rd(4'(i), d);
			`TB_CHK(d, 8'h00);
		end
		// flags: six sources set, a written 1 never sets the pin flag
		wr(`POMR_OFS_WDT, 8'h00);
		wr(`POMR_OFS_FLAG, 8'h00);
		for (int i = 0; i < 7; i++)
			if (i != 2)
				pulse(i);
		wr(`POMR_OFS_FLAG, 8'hF7);
		for (int i = 0; i < 7; i++)
		begin
			wr(`POMR_OFS_MASK, 8'(8'h01 << i));
			rd(`POMR_OFS_FLAG, d);
			`TB_CHK(d, 8'h73 & 8'(8'h01 << i));
		end
		wr(`POMR_OFS_MASK, 8'h7F);
		`TB_CHK(irq_req, 1'b0);
		pulse(8);
		`TB_CHK(irq_req, 1'b1);
		wr(`POMR_OFS_MASK, 8'h00);
		repeat (3) @(posedge clk_sys);
		`TB_CHK(irq_req, 1'b0);
		wr(`POMR_OFS_MASK, 8'h7F);
		pulse(-1);
		`TB_CHK(irq_req, 1'b0);
		// the global enable is also reachable as a register
		wr(`POMR_OFS_GIE, 8'h01);
		rd(`POMR_OFS_GIE, d);
		`TB_CHK(d, 8'h01);
		`TB_CHK(irq_req, 1'b1);
		wr(`POMR_OFS_GIE, 8'h00);
		// external pin: blocked while deselected, flagged when selected
		wr(`POMR_OFS_FLAG, 8'h00);
		p5_dir0 <= 1'b1;
		for (int s = 0; s < 2; s++)
		begin
			wr(`POMR_OFS_WDT, 8'(s << 6));
			@(posedge clk_sys);
			p5_pin <= 8'hFE;
			repeat (6) @(posedge clk_sys);
			rd(`POMR_OFS_FLAG, d);
			`TB_CHK(d, 8'(s << 2));
			rd(`POMR_OFS_P5, d);
			`TB_CHK(d, 8'hFE);
			p5_pin <= 8'hFF;
			repeat (6) @(posedge clk_sys);
			rd(`POMR_OFS_P5, d);
			`TB_CHK(d, 8'hFF);
		end
		report_and_stop();
	end
endmodule
